// file: logic/vec_irq_pkg.sv
// constants and types shared by the vectored interrupt and low-power block
`default_nettype none
package vec_irq_pkg;
	// register map, APB byte addresses
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_IE     = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_NMIE   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_VECTOR = 8'h10;
	// control fields
	localparam int unsigned CTRL_GIE_BIT  = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned MODE_W        = 3;
	// status fields
	localparam int unsigned ST_IDX_LSB     = 0;
	localparam int unsigned ST_VALID_BIT   = 4;
	localparam int unsigned ST_OP_LSB      = 5;
	localparam int unsigned ST_HANDLER_BIT = 11;
	localparam int unsigned ST_RESET_BIT   = 12;
	localparam int unsigned ST_DCO_BIT     = 13;
	// software-selected operating mode codes
	localparam logic [MODE_W-1:0] MODE_ACTIVE = 3'h0;
	localparam logic [MODE_W-1:0] MODE_S0     = 3'h1;
	localparam logic [MODE_W-1:0] MODE_S1     = 3'h2;
	localparam logic [MODE_W-1:0] MODE_S2     = 3'h3;
	localparam logic [MODE_W-1:0] MODE_S3     = 3'h4;
	localparam logic [MODE_W-1:0] MODE_S4     = 3'h5;
	// vector slots, one per priority level
	localparam int unsigned IRQ_N = 16;
	localparam int unsigned IDX_W = 4;
	localparam logic [15:0] VEC_BASE  = 16'hffe0;
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_NMI   = 16'hfffc;
	localparam logic [15:0] VEC_CMP   = 16'hfff6;
	localparam logic [15:0] VEC_WDT   = 16'hfff4;
	localparam logic [15:0] VEC_TA0   = 16'hfff2;
	localparam logic [15:0] VEC_TA1   = 16'hfff0;
	localparam logic [15:0] VEC_RX    = 16'hffee;
	localparam logic [15:0] VEC_TX    = 16'hffec;
	localparam logic [15:0] VEC_P2    = 16'hffe6;
	localparam logic [15:0] VEC_P1    = 16'hffe4;
	localparam int unsigned PRI_RESET = 15;
	localparam int unsigned PRI_NMI   = 14;
	localparam int unsigned PRI_CMP   = 11;
	localparam int unsigned PRI_WDT   = 10;
	localparam int unsigned PRI_TA0   = 9;
	localparam int unsigned PRI_TA1   = 8;
	localparam int unsigned PRI_RX    = 7;
	localparam int unsigned PRI_TX    = 6;
	localparam int unsigned PRI_P2    = 3;
	localparam int unsigned PRI_P1    = 2;
	// maskable slots that exist; the rest never request
	localparam logic [IRQ_N-1:0] IE_VALID     = 16'h0fcc;
	localparam logic [IRQ_N-1:0] UNUSED_SLOTS = 16'h3033;
	localparam logic [IRQ_N-1:0] IE_RESET     = 16'h0000;
	// non-maskable sub-enables
	localparam int unsigned NMIE_W      = 3;
	localparam int unsigned NMIE_URGENT = 0;
	localparam int unsigned NMIE_OSC    = 1;
	localparam int unsigned NMIE_ACCV   = 2;
	// operating state, one-hot
	typedef enum logic [5:0] {
		OP_ACTIVE = 6'h01,
		OP_S0     = 6'h02,
		OP_S1     = 6'h04,
		OP_S2     = 6'h08,
		OP_S3     = 6'h10,
		OP_S4     = 6'h20
	} op_t;
endpackage
`default_nettype wire

// file: logic/irq_prio_select.sv
// fixed-priority picker: highest pending index wins
`default_nettype none
module irq_prio_select
	import vec_irq_pkg::*;
(
	input  wire logic [IRQ_N-1:0] req,
	output logic                  valid,
	output logic [IDX_W-1:0]      idx
);
	localparam logic [IRQ_N-1:0] IDX_MASK [IDX_W] = '{16'haaaa, 16'hcccc, 16'hf0f0, 16'hff00};

	logic [IRQ_N-1:0] higher;
	logic [IRQ_N-1:0] grant;

	// chain of "something above is pending", then one-hot grant
	assign higher[IRQ_N-1] = 1'b0;
	generate
		for (genvar i = 0; i < IRQ_N; i++) begin : g_ent
			if (i > 0) begin : g_chain
				assign higher[i-1] = higher[i] | req[i];
			end
			assign grant[i] = req[i] & ~higher[i];
		end
		// binary encode of the single grant
		for (genvar b = 0; b < IDX_W; b++) begin : g_enc
			assign idx[b] = |(grant & IDX_MASK[b]);
		end
	endgenerate

	assign valid = |req;
endmodule // irq_prio_select
`default_nettype wire

// file: logic/vectored_irq_low_power_ctrl.sv
// vectored interrupt selection and low-power clock gating with an APB slave
`default_nettype none
module vectored_irq_low_power_ctrl
	import vec_irq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              power_up_event,
	input  wire logic              ext_reset_event,
	input  wire logic              watchdog_expiry_flag,
	input  wire logic              wdt_interval_mode,
	input  wire logic              flash_key_violation,
	input  wire logic              urgent_pin_flag,
	input  wire logic              osc_fault_flag,
	input  wire logic              flash_access_violation_flag,
	input  wire logic              comparator_event_flag,
	input  wire logic [2:0]        capture_compare_flag,
	input  wire logic              timer_overflow_flag,
	input  wire logic              serial_rx_flag,
	input  wire logic              serial_tx_flag,
	input  wire logic [7:0]        port_two_pin_flags,
	input  wire logic [7:0]        port_one_pin_flags,
	input  wire logic              digital_oscillator_in_use,
	input  wire logic              cpu_irq_ack,
	input  wire logic              cpu_irq_return,
	output logic                   irq_req,
	output logic      [15:0]       irq_vector,
	output logic                   cpu_run,
	output logic                   mclk_en,
	output logic                   peripheral_clock_en,
	output logic                   aclk_en,
	output logic                   dcgen_en,
	output logic                   xosc_en
);
	// control state
	logic              gie;
	logic [MODE_W-1:0] mode;
	logic [IRQ_N-1:0]  ie;
	logic [NMIE_W-1:0] nmie;
	logic              saved_gie;
	logic [MODE_W-1:0] saved_mode;
	logic              in_handler;
	logic              reset_pend;
	logic              dco_used;
	op_t               op;

	// next values
	logic              next_gie;
	logic [MODE_W-1:0] next_mode;
	logic              next_in_handler;
	op_t               next_op;
	logic [5:0]        next_clk;
	logic              next_dco_used;

	// apb decode
	wire setup       = psel & ~penable;
	wire access_done = psel & penable & pready;
	wire hit_ctrl    = (paddr == OFF_CTRL);
	wire hit_ie      = (paddr == OFF_IE);
	wire hit_nmie    = (paddr == OFF_NMIE);
	wire hit_status  = (paddr == OFF_STATUS);
	wire hit_vector  = (paddr == OFF_VECTOR);
	wire mapped      = hit_ctrl | hit_ie | hit_nmie | hit_status | hit_vector;
	wire wr_ctrl     = access_done & pwrite & hit_ctrl;
	wire wr_ie       = access_done & pwrite & hit_ie;
	wire wr_nmie     = access_done & pwrite & hit_nmie;
	wire [MODE_W-1:0] wr_mode = pwdata[CTRL_MODE_LSB +: MODE_W];

	// system reset causes; watchdog expiry only resets outside interval mode
	wire reset_event = power_up_event | ext_reset_event | flash_key_violation
		| (watchdog_expiry_flag & ~wdt_interval_mode);

	// source flags come straight from the peripherals, no local copies
	logic [IRQ_N-1:0] src;
	always_comb begin
		src = '0;
		src[PRI_CMP] = comparator_event_flag;
		src[PRI_WDT] = watchdog_expiry_flag & wdt_interval_mode;
		src[PRI_TA0] = capture_compare_flag[0];
		src[PRI_TA1] = |{capture_compare_flag[2:1], timer_overflow_flag};
		src[PRI_RX]  = serial_rx_flag;
		src[PRI_TX]  = serial_tx_flag;
		src[PRI_P2]  = |port_two_pin_flags;
		src[PRI_P1]  = |port_one_pin_flags;
	end

	// non-maskable group ignores the global enable
	wire [NMIE_W-1:0] nmi_src = {flash_access_violation_flag, osc_fault_flag, urgent_pin_flag};
	wire nmi_req = |(nmi_src & nmie);

	// request vector: maskable gated by global and own enable
	logic [IRQ_N-1:0] req;
	always_comb begin
		req = src & ie & IE_VALID & {IRQ_N{gie}};
		req[PRI_NMI]   = nmi_req;
		req[PRI_RESET] = reset_pend;
	end

	logic             sel_valid;
	logic [IDX_W-1:0] sel_idx;

	irq_prio_select u_sel (
		.req   (req),
		.valid (sel_valid),
		.idx   (sel_idx)
	);

	// vector word address from slot index
	wire [15:0] sel_vector = 16'(VEC_BASE + {11'h000, sel_idx, 1'b0});
	wire ack_take  = cpu_irq_ack & irq_req;
	wire ack_reset = ack_take & (irq_vector == VEC_RESET);
	wire ack_irq   = ack_take & ~ack_reset;
	wire ret_take  = cpu_irq_return & in_handler;

	// global enable, sleep mode and handler bookkeeping
	always_comb begin
		next_gie = gie;
		next_mode = mode;
		next_in_handler = in_handler;
		if (reset_event) begin
			next_gie = 1'b0;
			next_mode = MODE_ACTIVE;
			next_in_handler = 1'b0;
		end else if (ack_irq) begin
			next_gie = 1'b0; // handler runs awake, masked by default
			next_mode = MODE_ACTIVE;
			next_in_handler = 1'b1;
		end else if (ret_take) begin
			next_gie = saved_gie;
			next_mode = saved_mode;
			next_in_handler = 1'b0;
		end else if (wr_ctrl) begin
			next_gie = pwdata[CTRL_GIE_BIT];
			if (wr_mode <= MODE_S4) begin
				next_mode = wr_mode;
			end
		end
	end

	// a pending request overrides the sleep mode and wakes the core
	always_comb begin
		if (sel_valid) begin
			next_op = OP_ACTIVE;
		end else begin
			case (mode)
				MODE_S0: next_op = OP_S0;
				MODE_S1: next_op = OP_S1;
				MODE_S2: next_op = OP_S2;
				MODE_S3: next_op = OP_S3;
				MODE_S4: next_op = OP_S4;
				default: next_op = OP_ACTIVE;
			endcase
		end
	end

	// oscillator usage is only learnt while active
	assign next_dco_used = (op == OP_ACTIVE) ? digital_oscillator_in_use : dco_used;

	// clock gates {cpu, main, peripheral, aux, dc generator, crystal}
	always_comb begin
		case (next_op)
			OP_ACTIVE: next_clk = 6'h3f;
			OP_S0:     next_clk = 6'h0f;
			OP_S1:     next_clk = {4'h3, next_dco_used, 1'b1}; // dc generator bit only
			OP_S2:     next_clk = 6'h07;
			OP_S3:     next_clk = 6'h05;
			OP_S4:     next_clk = 6'h00;
			default:   next_clk = 6'h3f;
		endcase
	end

	// control registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gie <= 1'b0;
			mode <= MODE_ACTIVE;
			in_handler <= 1'b0;
			op <= OP_ACTIVE;
			dco_used <= 1'b1;
		end else begin
			gie <= next_gie;
			mode <= next_mode;
			in_handler <= next_in_handler;
			op <= next_op;
			dco_used <= next_dco_used;
		end
	end

	// context saved on entry to a handler, single level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			saved_gie <= 1'b0;
			saved_mode <= MODE_ACTIVE;
		end else if (ack_irq && !reset_event) begin
			saved_gie <= gie;
			saved_mode <= mode;
		end
	end

	// reset request: power-up sets it, a new cause beats the acknowledge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reset_pend <= 1'b1;
		end else begin
			reset_pend <= reset_event | (reset_pend & ~ack_reset);
		end
	end

	// enable registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ie <= IE_RESET;
			nmie <= '0;
		end else begin
			if (wr_ie) ie <= pwdata[IRQ_N-1:0] & IE_VALID;
			if (wr_nmie) nmie <= pwdata[NMIE_W-1:0];
		end
	end

	// registered outputs toward the core and clock system
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
			irq_vector <= VEC_RESET;
			{cpu_run, mclk_en, peripheral_clock_en, aclk_en, dcgen_en, xosc_en} <= 6'h3f;
		end else begin
			irq_req <= sel_valid;
			irq_vector <= sel_vector;
			{cpu_run, mclk_en, peripheral_clock_en, aclk_en, dcgen_en, xosc_en} <= next_clk;
		end
	end

	// read data selection
	wire [DATA_W-1:0] rd_ctrl = (DATA_W'(gie) << CTRL_GIE_BIT) | (DATA_W'(mode) << CTRL_MODE_LSB);
	wire [DATA_W-1:0] rd_status = (DATA_W'(sel_idx) << ST_IDX_LSB)
		| (DATA_W'(sel_valid) << ST_VALID_BIT) | (DATA_W'(op) << ST_OP_LSB)
		| (DATA_W'(in_handler) << ST_HANDLER_BIT) | (DATA_W'(reset_pend) << ST_RESET_BIT)
		| (DATA_W'(dco_used) << ST_DCO_BIT);
	wire [DATA_W-1:0] rdata = hit_ctrl ? rd_ctrl
		: hit_ie ? DATA_W'(ie)
		: hit_nmie ? DATA_W'(nmie)
		: hit_status ? rd_status
		: hit_vector ? DATA_W'(irq_vector)
		: '0;

	// apb answer: ready in the first access cycle, error on unmapped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			prdata <= rdata;
		end else if (access_done) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence ack_seq;
		cpu_irq_ack && irq_req && irq_vector != VEC_RESET && !reset_event;
	endsequence
	sequence wake_seq;
		op != OP_ACTIVE && sel_valid;
	endsequence

	reset_vector_a: assert property (reset_event |=> ##1 (irq_req && irq_vector == VEC_RESET))
		else $error("reset cause did not select the top vector");
	nmi_vector_a: assert property ((urgent_pin_flag && nmie[NMIE_URGENT] && !reset_pend)
		|=> (irq_req && irq_vector == VEC_NMI))
		else $error("urgent pin did not select the non-maskable vector");
	global_mask_a: assert property ((!gie && !reset_pend && !nmi_req) |=> !irq_req)
		else $error("maskable request passed with global enable clear");
	cmp_vector_a: assert property ((irq_req && irq_vector == VEC_CMP)
		|-> $past(comparator_event_flag && gie && ie[PRI_CMP]))
		else $error("comparator vector without an enabled comparator event");
	wdt_vector_a: assert property ((irq_req && irq_vector == VEC_WDT)
		|-> $past(watchdog_expiry_flag && wdt_interval_mode && gie))
		else $error("watchdog vector outside interval mode");
	unused_slot_a: assert property (irq_req |-> !UNUSED_SLOTS[irq_vector[4:1]])
		else $error("unassigned vector slot selected");
	prio_order_a: assert property ((comparator_event_flag && serial_rx_flag && gie
		&& ie[PRI_CMP] && ie[PRI_RX] && !reset_pend && !nmi_req)
		|=> irq_vector == VEC_CMP)
		else $error("lower priority served first");
	wake_up_a: assert property (wake_seq |=> (op == OP_ACTIVE && cpu_run && mclk_en))
		else $error("pending request did not wake the core");
	handler_entry_a: assert property (ack_seq |=> (in_handler && mode == MODE_ACTIVE
		&& saved_mode == $past(mode)))
		else $error("sleep mode not saved on handler entry");
	sleep_zero_a: assert property ((op == OP_S0) |-> (!cpu_run && !mclk_en
		&& peripheral_clock_en && aclk_en))
		else $error("sleep zero clock gating wrong");
	sleep_three_a: assert property ((op == OP_S3) |-> (!mclk_en && !peripheral_clock_en
		&& !dcgen_en && aclk_en))
		else $error("sleep three clock gating wrong");
	sleep_four_a: assert property ((op == OP_S4) |-> (!aclk_en && !dcgen_en
		&& !xosc_en && !peripheral_clock_en))
		else $error("sleep four left a clock running");
endmodule // vectored_irq_low_power_ctrl
`default_nettype wire

// file: verification/cpu_core_model.sv
// behavioural cpu core: takes vectors, runs a short handler, returns
`default_nettype none
module cpu_core_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        en,
	input  wire logic [3:0]  lag,
	input  wire logic        cpu_run,
	input  wire logic        irq_req,
	input  wire logic [15:0] irq_vector,
	output logic             cpu_irq_ack,
	output logic             cpu_irq_return,
	output logic             in_isr,
	output logic [15:0]      taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt;
	// a halted core cannot acknowledge, so wait for cpu_run; busy blocks a double ack
	always_ff @(posedge clk) begin
		cpu_irq_ack <= 1'b0;
		cpu_irq_return <= 1'b0;
		if (!rst_n) begin
			cnt <= 5'h0;
			in_isr <= 1'b0;
			taken <= 16'h0;
		end else if (in_isr) begin
			cnt <= cnt + 5'h1;
			if (taken != 16'hfffe && cnt == 5'hc)
				cpu_irq_return <= 1'b1; // reset vector never returns
			if (cnt == 5'he) begin
				in_isr <= 1'b0;
				cnt <= 5'h0;
			end
		end else if (en && irq_req && cpu_run) begin
			cnt <= cnt + 5'h1;
			if (cnt == {1'b0, lag}) begin
				cpu_irq_ack <= 1'b1;
				taken <= irq_vector;
				in_isr <= 1'b1;
				cnt <= 5'h0;
			end
		end else
			cnt <= 5'h0;
	end
endmodule // cpu_core_model
`default_nettype wire

// file: verification/vectored_irq_low_power_ctrl_test.sv
// self-checking bench for vectored interrupt and low-power clock gating
`default_nettype none
module vectored_irq_low_power_ctrl_test;
	import vec_irq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic pwr_up, ext_rst, wdt_flag, wdt_int, key_v, urg, osc, accv, cmpf, ovf, rx, tx;
	logic [2:0] ccf;
	logic [7:0] p2, p1;
	logic dco_use, ack, ret, irq_req, cpu_run, mclk, pclk, aclk, dcg, xosc, en, in_isr;
	logic [3:0] lag;
	logic [15:0] irq_vector, taken;
	int num_errors = 0;
	int check_count = 0;
	logic [15:0] vtab [9] = '{16'hfffc, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
		16'hffee, 16'hffec, 16'hffe6, 16'hffe4};
	logic [5:0] ctab [6] = '{6'h3f, 6'h0f, 6'h0f, 6'h07, 6'h05, 6'h00};

	vectored_irq_low_power_ctrl vectored_irq_low_power_ctrl_inst (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .power_up_event(pwr_up),
		.ext_reset_event(ext_rst), .watchdog_expiry_flag(wdt_flag),
		.wdt_interval_mode(wdt_int), .flash_key_violation(key_v), .urgent_pin_flag(urg),
		.osc_fault_flag(osc), .flash_access_violation_flag(accv),
		.comparator_event_flag(cmpf), .capture_compare_flag(ccf), .timer_overflow_flag(ovf),
		.serial_rx_flag(rx), .serial_tx_flag(tx), .port_two_pin_flags(p2),
		.port_one_pin_flags(p1), .digital_oscillator_in_use(dco_use), .cpu_irq_ack(ack),
		.cpu_irq_return(ret), .irq_req(irq_req), .irq_vector(irq_vector), .cpu_run(cpu_run),
		.mclk_en(mclk), .peripheral_clock_en(pclk), .aclk_en(aclk), .dcgen_en(dcg),
		.xosc_en(xosc));
	cpu_core_model cpu_core_model_inst (.clk(clk), .rst_n(rst_n), .en(en), .lag(lag),
		.cpu_run(cpu_run), .irq_req(irq_req), .irq_vector(irq_vector), .cpu_irq_ack(ack),
		.cpu_irq_return(ret), .in_isr(in_isr), .taken(taken));

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic hang;
		num_errors++;
		end_of_test;
	endtask

	task automatic cmp(input logic [31:0] a, input logic [31:0] e);
		check_count++;
		if (a !== e) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	// bounded wait: 0 vector, 1 cpu_run, 2 irq_req, 3 core in handler
	task automatic wait_for(input int k, input logic [15:0] v);
		logic [15:0] o;
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			case (k)
				0: o = irq_req === 1'b1 ? irq_vector : 16'h0;
				1: o = {15'h0, cpu_run};
				2: o = {15'h0, irq_req};
				default: o = {15'h0, in_isr};
			endcase
			if (o === v) begin
				check_count++;
				return;
			end
		end
		$display("ERROR at %0t: got %h expected %h", $time, o, v);
		hang;
	endtask

	// one apb transfer; request held until pready seen high at an edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50)
			hang;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		cmp(r, x);
		cmp({31'h0, e}, {31'h0, xe});
	endtask

	task automatic src(input int i, input logic v);
		@(posedge clk);
		case (i)
			0: urg <= v;
			1: cmpf <= v;
			2: wdt_flag <= v;
			3: ccf[0] <= v;
			4: {ccf[2:1], ovf} <= {v, v, v};
			5: rx <= v;
			6: tx <= v;
			7: p2 <= v ? 8'h80 : 8'h00;
			default: p1 <= v ? 8'h10 : 8'h00;
		endcase
	endtask

	task automatic clk_chk(input logic [5:0] e);
		cmp(32'({cpu_run, mclk, pclk, aclk, dcg, xosc}), 32'(e));
	endtask

	initial begin
		{rst_n, psel, penable, pwrite, pwr_up, ext_rst, wdt_flag, wdt_int, key_v} = '0;
		{urg, osc, accv, cmpf, ovf, rx, tx, ccf, p2, p1} = '0;
		paddr = '0;
		pwdata = '0;
		dco_use = 1'b1;
		en = 1'b1;
		lag = 4'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wait_for(0, 16'hfffe);
		clk_chk(6'h3f);
		wait_for(2, 16'h0);
		// every reset cause, watchdog still in reset role
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{pwr_up, ext_rst, key_v, wdt_flag} <= 4'h8 >> i;
			@(posedge clk);
			{pwr_up, ext_rst, key_v, wdt_flag} <= 4'h0;
			wait_for(0, 16'hfffe);
			wait_for(2, 16'h0);
		end
		$display("test reset_causes done");
		en <= 1'b0;
		wdt_int <= 1'b1;
		rd(OFF_CTRL, 32'h0, 1'b0);
		wr(OFF_IE, 32'hffff);
		rd(OFF_IE, 32'h0fcc, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		$display("test registers done");
		src(8, 1'b1);
		repeat (3) @(posedge clk);
		#1 cmp({31'h0, irq_req}, 32'h0);
		wr(OFF_CTRL, 32'h1);
		wait_for(0, 16'hffe4);
		wr(OFF_IE, 32'h0);
		wait_for(2, 16'h0);
		src(8, 1'b0);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_NMIE, 32'h2);
		@(posedge clk);
		{urg, accv} <= 2'b11;
		repeat (3) @(posedge clk);
		#1 cmp({31'h0, irq_req}, 32'h0);
		@(posedge clk);
		osc <= 1'b1;
		wait_for(0, 16'hfffc);
		@(posedge clk);
		{urg, accv, osc} <= 3'b000;
		wait_for(2, 16'h0);
		$display("test enables done");
		// one source for each of the nine vectors below reset at once, peeled from the top
		wr(OFF_IE, 32'hffff);
		wr(OFF_NMIE, 32'h7);
		wr(OFF_CTRL, 32'h1);
		for (int i = 0; i < 9; i++)
			src(i, 1'b1);
		for (int i = 0; i < 9; i++) begin
			wait_for(0, vtab[i]);
			src(i, 1'b0);
		end
		wait_for(2, 16'h0);
		$display("test priority done");
		for (int i = 0; i < 6; i++) begin
			wr(OFF_CTRL, 32'(i) << 1);
			repeat (3) @(posedge clk);
			#1 clk_chk(ctab[i]);
		end
		wr(OFF_CTRL, 32'h0);
		@(posedge clk);
		dco_use <= 1'b0;
		repeat (3) @(posedge clk);
		wr(OFF_CTRL, 32'h4);
		repeat (3) @(posedge clk);
		#1 clk_chk(6'h0d);
		rd(OFF_STATUS, 32'h0080, 1'b0);
		$display("test sleep done");
		@(posedge clk);
		// wake from sleep three, slow core, then fall back asleep
		dco_use <= 1'b1;
		en <= 1'b1;
		lag <= 4'h3;
		wr(OFF_IE, 32'h0080);
		wr(OFF_CTRL, 32'h9);
		src(5, 1'b1);
		wait_for(1, 16'h1);
		wait_for(3, 16'h1);
		src(5, 1'b0);
		cmp(32'(taken), 32'hffee);
		wait_for(1, 16'h0);
		#1 clk_chk(6'h05);
		$display("test wake done");
		end_of_test;
	end
endmodule // vectored_irq_low_power_ctrl_test
`default_nettype wire
